/* rtl/meter_cfg_regs.sv */
// Metering configuration and identification register bank
`timescale 1ns/1ps
module meter_cfg_regs
    import meter_cfg_pkg::*;
#(
    parameter int FIXED_US = PULSE_FIXED_US,
    parameter int MS_TICKS = US_IN_MS,
    // Arbitrary neutral identity value
    parameter logic IDENTITY_BIT = 1'b0
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [DATA_W-1:0] REG_RDATA,
    output logic REG_RVALID,
    output logic BURST_OK,
    output logic CRC_APPEND,
    output logic OUTSIDE_REFERENCE_SELECT,
    output logic [15:0] TRIM_OFFSET,
    output logic [15:0] TRIM_GAIN,
    input wire logic [3:0] PULSE_FIRE,
    output logic PULSE_OUTPUT_ONE_N,
    output logic PULSE_OUTPUT_TWO_N,
    output logic PULSE_OUTPUT_THREE_N,
    output logic PULSE_OUTPUT_FOUR_N,
    input wire logic FIRST_EVENT,
    input wire logic SECOND_EVENT,
    output logic INTERRUPT_PIN_FIRST_N,
    output logic INTERRUPT_PIN_SECOND_N,
    input wire logic SAG_ACTIVE,
    input wire logic SURGE_ACTIVE,
    input wire logic SAG_CYCLE_DONE,
    input wire logic SURGE_CYCLE_DONE,
    output logic SAG_SURGE_EVENT,
    output logic PULSE_ACCUMULATOR_CLEAR,
    output logic ACCUMULATION_ENABLE
);
    generate
        if (MS_TICKS < 1 || MS_TICKS > 65536 || FIXED_US < 1) begin : g_bad
            $error("tick counts must be positive");
        end
    endgenerate

    localparam logic [5:0] TICK_LAST = 6'(TICK_CYCLES - 1);
    localparam logic [15:0] MS_LAST = 16'(MS_TICKS - 1);

    logic [31:0] pulse_width_config;
    logic [31:0] temperature_trim;
    logic [15:0] global_config_one;
    logic [5:0] tick_cnt;
    logic tick_us;
    logic [15:0] ms_cnt;
    logic tick_ms;
    logic [SETTLE_W-1:0] settle_cnt;
    logic sag_q;
    logic surge_q;
    logic [3:0] shaped_n;

    // Address decode
    wire sel_width = (REG_ADDR == OFS_PULSE_WIDTH_CONFIG);
    wire sel_ident = (REG_ADDR == OFS_PART_IDENTITY);
    wire sel_trim = (REG_ADDR == OFS_TEMPERATURE_TRIM);
    wire sel_cfg1 = (REG_ADDR == OFS_GLOBAL_CONFIG_ONE);
    wire wr_width = REG_WR && sel_width;
    wire wr_trim = REG_WR && sel_trim;
    wire wr_cfg1 = REG_WR && sel_cfg1;
    wire acc_clear_req = wr_cfg1 && REG_WDATA[POS_ACC_CLEAR];

    // Field views
    wire [3:0] width_select = pulse_width_config[POS_OUT4_SEL:POS_OUT1_SEL];
    wire [WIDTH_VALUE_W-1:0] pulse_width_value = pulse_width_config[WIDTH_VALUE_W-1:0];
    wire outside_reference_select = global_config_one[POS_OUTSIDE_REF];
    wire interrupt_combine = global_config_one[POS_INT_COMBINE];
    wire burst_enable = global_config_one[POS_BURST_EN];
    wire sag_surge_edge_mode = global_config_one[POS_DS_MODE];
    wire [1:0] accumulation_settle_time = global_config_one[POS_SETTLE+1:POS_SETTLE];

    // Read data assembly; reserved bits read zero
    wire [31:0] ident_word = {11'h000, IDENTITY_BIT, 20'h00000};
    wire [31:0] cfg1_word = {16'h0000, global_config_one};
    wire [31:0] next_rdata = sel_width ? pulse_width_config :
                             sel_ident ? ident_word :
                             sel_trim ? temperature_trim :
                             sel_cfg1 ? cfg1_word : 32'h0000_0000;
    wire in_burst_range = ((REG_ADDR >= BURST_LO_START) && (REG_ADDR <= BURST_LO_END)) ||
                          ((REG_ADDR >= BURST_HI_START) && (REG_ADDR <= BURST_HI_END));
    wire next_burst_ok = REG_RD && burst_enable && in_burst_range;

    // Settle delay selection
    wire [SETTLE_W-1:0] settle_load = (accumulation_settle_time == 2'h0) ? SETTLE_CODE0_MS :
                                      (accumulation_settle_time == 2'h1) ? SETTLE_CODE1_MS :
                                      (accumulation_settle_time == 2'h2) ? SETTLE_CODE2_MS :
                                      SETTLE_CODE3_MS;

    // Dip and swell event selection
    wire sag_edge = SAG_ACTIVE != sag_q;
    wire surge_edge = SURGE_ACTIVE != surge_q;
    wire repeat_event = (SAG_ACTIVE && SAG_CYCLE_DONE) || (SURGE_ACTIVE && SURGE_CYCLE_DONE);
    wire next_sag_surge_event = sag_surge_edge_mode ? (sag_edge || surge_edge) :
                                repeat_event;

    wire next_second_n = !(SECOND_EVENT || (interrupt_combine && FIRST_EVENT));
    wire next_first_n = !FIRST_EVENT;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pulse_width_config <= RST_PULSE_WIDTH_CONFIG;
        end else if (wr_width) begin
            pulse_width_config <= {9'h000, REG_WDATA[22:0]};
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            temperature_trim <= RST_TEMPERATURE_TRIM;
        end else if (wr_trim) begin
            temperature_trim <= REG_WDATA;
        end
    end

    // Clear bit is never stored, so it always reads back zero
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            global_config_one <= RST_GLOBAL_CONFIG_ONE;
        end else if (wr_cfg1) begin
            global_config_one <= REG_WDATA[15:0] & CFG1_WRITE_MASK;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            REG_RDATA <= 32'h0000_0000;
            REG_RVALID <= 1'b0;
            BURST_OK <= 1'b0;
        end else begin
            REG_RDATA <= REG_RD ? next_rdata : 32'h0000_0000;
            REG_RVALID <= REG_RD;
            BURST_OK <= next_burst_ok;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            CRC_APPEND <= 1'b1;
            OUTSIDE_REFERENCE_SELECT <= 1'b0;
            TRIM_OFFSET <= 16'h0000;
            TRIM_GAIN <= 16'h0000;
        end else begin
            CRC_APPEND <= !burst_enable;
            OUTSIDE_REFERENCE_SELECT <= outside_reference_select;
            TRIM_OFFSET <= temperature_trim[31:POS_TRIM_OFFSET];
            TRIM_GAIN <= temperature_trim[POS_TRIM_OFFSET-1:0];
        end
    end

    // Microsecond and millisecond enables
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tick_cnt <= 6'h00;
            tick_us <= 1'b0;
        end else begin
            tick_cnt <= (tick_cnt == TICK_LAST) ? 6'h00 : tick_cnt + 6'h01;
            tick_us <= (tick_cnt == TICK_LAST);
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ms_cnt <= 16'h0000;
            tick_ms <= 1'b0;
        end else begin
            tick_ms <= tick_us && (ms_cnt == MS_LAST);
            if (tick_us) begin
                ms_cnt <= (ms_cnt == MS_LAST) ? 16'h0000 : ms_cnt + 16'h0001;
            end
        end
    end

    // Settle restarts on every accumulator clear; reset uses code 0
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            settle_cnt <= SETTLE_CODE0_MS;
            ACCUMULATION_ENABLE <= 1'b0;
        end else begin
            if (acc_clear_req) begin
                settle_cnt <= settle_load;
            end else if (tick_ms && (settle_cnt != '0)) begin
                settle_cnt <= settle_cnt - 1'b1;
            end
            ACCUMULATION_ENABLE <= (settle_cnt == '0) && !acc_clear_req;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PULSE_ACCUMULATOR_CLEAR <= 1'b0;
        end else begin
            PULSE_ACCUMULATOR_CLEAR <= acc_clear_req;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            INTERRUPT_PIN_FIRST_N <= 1'b1;
            INTERRUPT_PIN_SECOND_N <= 1'b1;
        end else begin
            INTERRUPT_PIN_FIRST_N <= next_first_n;
            INTERRUPT_PIN_SECOND_N <= next_second_n;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sag_q <= 1'b0;
            surge_q <= 1'b0;
            SAG_SURGE_EVENT <= 1'b0;
        end else begin
            sag_q <= SAG_ACTIVE;
            surge_q <= SURGE_ACTIVE;
            SAG_SURGE_EVENT <= next_sag_surge_event;
        end
    end

    // Shaper outputs are flops inside each instance
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_shape
            pulse_shaper #(
                .FIXED_US(FIXED_US)
            ) u_shape (
                .clk(CLK),
                .rst(RST),
                .tick_us(tick_us),
                .clear(PULSE_ACCUMULATOR_CLEAR),
                .fire(PULSE_FIRE[gi]),
                .use_prog(width_select[gi]),
                .prog_width(pulse_width_value),
                .pulse_n(shaped_n[gi])
            );
        end
    endgenerate

    assign PULSE_OUTPUT_ONE_N = shaped_n[0];
    assign PULSE_OUTPUT_TWO_N = shaped_n[1];
    assign PULSE_OUTPUT_THREE_N = shaped_n[2];
    assign PULSE_OUTPUT_FOUR_N = shaped_n[3];

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_clear_write;
        REG_WR && sel_cfg1 && REG_WDATA[POS_ACC_CLEAR];
    endsequence
    sequence s_clear_pulse;
        PULSE_ACCUMULATOR_CLEAR ##1 !PULSE_ACCUMULATOR_CLEAR;
    endsequence

    a_clear_pulse: assert property (
        s_clear_write ##1 !acc_clear_req |-> s_clear_pulse)
        else $error("accumulator clear not a single pulse");
    a_clear_reads_zero: assert property (
        (REG_RD && sel_cfg1) |=> !REG_RDATA[POS_ACC_CLEAR])
        else $error("clear bit read back set");
    a_ident_read: assert property (
        (REG_RD && sel_ident) |=> (REG_RDATA == {11'h000, IDENTITY_BIT, 20'h00000}))
        else $error("identity word wrong");
    a_reserved_zero: assert property (
        (REG_RD && sel_cfg1) |=> (REG_RDATA[31:16] == 16'h0000 && REG_RDATA[14:13] == 2'h0))
        else $error("reserved bits read nonzero");
    a_combine_second: assert property (
        (interrupt_combine && FIRST_EVENT) |=> !INTERRUPT_PIN_SECOND_N)
        else $error("combined event missing on second pin");
    a_first_own: assert property (
        1'b1 |=> (INTERRUPT_PIN_FIRST_N == !$past(FIRST_EVENT)))
        else $error("first pin not tracking its events");
    a_crc_burst: assert property (
        $past(burst_enable) |-> !CRC_APPEND)
        else $error("crc appended in burst mode");
    a_burst_range: assert property (
        (REG_RD && burst_enable && (REG_ADDR == BURST_HI_END)) |=> BURST_OK)
        else $error("burst read refused in range");
    a_edge_mode: assert property (
        (sag_surge_edge_mode && ($changed(SAG_ACTIVE) || $changed(SURGE_ACTIVE)))
        |=> SAG_SURGE_EVENT)
        else $error("edge mode event missing");
    a_repeat_mode: assert property (
        (!sag_surge_edge_mode && SAG_ACTIVE && SAG_CYCLE_DONE) |=> SAG_SURGE_EVENT)
        else $error("repeat mode event missing");
    a_settle_zero: assert property (
        (s_clear_write and (accumulation_settle_time == 2'h3))
        ##1 (!acc_clear_req)[*2] |-> ACCUMULATION_ENABLE)
        else $error("zero settle did not enable accumulation");
endmodule : meter_cfg_regs

/* rtl/meter_cfg_pkg.sv */
// Constants for the metering configuration register bank
package meter_cfg_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] OFS_PULSE_WIDTH_CONFIG = 12'h425;
    localparam logic [11:0] OFS_PART_IDENTITY = 12'h472;
    localparam logic [11:0] OFS_TEMPERATURE_TRIM = 12'h474;
    localparam logic [11:0] OFS_GLOBAL_CONFIG_ONE = 12'h481;
    localparam logic [11:0] BURST_LO_START = 12'h500;
    localparam logic [11:0] BURST_LO_END = 12'h63C;
    localparam logic [11:0] BURST_HI_START = 12'h680;
    localparam logic [11:0] BURST_HI_END = 12'h6BC;
    // Pulse width config fields
    localparam int POS_OUT4_SEL = 22;
    localparam int POS_OUT1_SEL = 19;
    localparam int WIDTH_VALUE_W = 19;
    localparam logic [31:0] RST_PULSE_WIDTH_CONFIG = 32'h0000_0000;
    // Identity and trim fields
    localparam int POS_PART_IDENTITY = 20;
    localparam int POS_TRIM_OFFSET = 16;
    localparam logic [31:0] RST_TEMPERATURE_TRIM = 32'h0000_0000;
    // Global config one fields
    localparam int POS_OUTSIDE_REF = 15;
    localparam int POS_INT_COMBINE = 12;
    localparam int POS_BURST_EN = 11;
    localparam int POS_DS_MODE = 10;
    localparam int POS_SETTLE = 8;
    localparam int POS_ACC_CLEAR = 5;
    localparam logic [15:0] CFG1_WRITE_MASK = 16'h9F00;
    localparam logic [15:0] RST_GLOBAL_CONFIG_ONE = 16'h0000;
    // Timing
    localparam int CLK_MHZ = 50;
    localparam int TICK_US = 1;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int US_IN_MS = 1000;
    localparam int PULSE_FIXED_MS = 80;
    localparam int PULSE_FIXED_US = PULSE_FIXED_MS * US_IN_MS;
    localparam int SETTLE_W = 9;
    localparam logic [8:0] SETTLE_CODE0_MS = 9'h040;
    localparam logic [8:0] SETTLE_CODE1_MS = 9'h080;
    localparam logic [8:0] SETTLE_CODE2_MS = 9'h100;
    localparam logic [8:0] SETTLE_CODE3_MS = 9'h000;
    localparam int PERIOD_W = 20;
endpackage : meter_cfg_pkg

/* rtl/pulse_shaper.sv */
// Active-low pulse width shaper for one frequency output
`timescale 1ns/1ps
module pulse_shaper
    import meter_cfg_pkg::*;
#(
    parameter int FIXED_US = PULSE_FIXED_US
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick_us,
    input wire logic clear,
    input wire logic fire,
    input wire logic use_prog,
    input wire logic [WIDTH_VALUE_W-1:0] prog_width,
    output logic pulse_n
);
    localparam logic [PERIOD_W-1:0] FIXED_W = PERIOD_W'(FIXED_US);
    localparam logic [PERIOD_W-1:0] PERIOD_MAX = {PERIOD_W{1'b1}};

    generate
        if (FIXED_US >= (1 << (PERIOD_W - 1))) begin : g_bad
            $error("FIXED_US too large for period counter");
        end
    endgenerate

    logic [PERIOD_W-1:0] period;
    logic [PERIOD_W-1:0] remain;
    wire [PERIOD_W-1:0] half_period = period >> 1;
    // Fixed width shrinks to half the period so fast pulses still separate
    wire [PERIOD_W-1:0] fixed_width = (half_period < FIXED_W) ? half_period : FIXED_W;
    wire [PERIOD_W-1:0] next_width = use_prog ? {1'b0, prog_width} :
                                     fixed_width;
    wire period_step = tick_us && (period != PERIOD_MAX);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            period <= PERIOD_MAX;
        end else if (clear || fire) begin
            period <= '0;
        end else if (period_step) begin
            period <= period + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            remain <= '0;
            pulse_n <= 1'b1;
        end else if (clear) begin
            remain <= '0;
            pulse_n <= 1'b1;
        end else if (fire && (next_width != '0)) begin
            remain <= next_width;
            pulse_n <= 1'b0;
        end else if (tick_us && (remain != '0)) begin
            remain <= remain - 1'b1;
            pulse_n <= (remain == PERIOD_W'(1));
        end
    end

    a_fire_low: assert property (@(posedge clk) disable iff (rst)
        (fire && !clear && use_prog && (prog_width != '0)) |=> !pulse_n)
        else $error("programmed pulse did not start");
    a_fixed_start: assert property (@(posedge clk) disable iff (rst)
        (fire && !clear && !use_prog && (fixed_width != '0))
        |=> (!pulse_n && remain == $past(fixed_width)))
        else $error("fixed pulse width not loaded");
endmodule : pulse_shaper

/* test/host_model.sv */
// Host side of the register port: strobed single-word accesses
`timescale 1ns/1ps
module host_model
    import meter_cfg_pkg::*;
(
    input wire logic CLK,
    output logic [ADDR_W-1:0] REG_ADDR,
    output logic REG_WR,
    output logic [DATA_W-1:0] REG_WDATA,
    output logic REG_RD
);
    initial begin
        REG_ADDR = '0;
        REG_WR = 1'b0;
        REG_WDATA = '0;
        REG_RD = 1'b0;
    end

    // Released lines show the inverse, so a stale address or word never looks valid
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= wr;
        REG_RD <= ~wr;
        @(posedge CLK);
        REG_WR <= 1'b0;
        REG_RD <= 1'b0;
        REG_ADDR <= ~a;
        REG_WDATA <= ~d;
    endtask : access
endmodule : host_model

/* test/tb_metering_config_registers.sv */
// Self-checking bench for the metering configuration register bank
`timescale 1ns/1ps
module tb_metering_config_registers;
    import meter_cfg_pkg::*;
    localparam int FIX_US = 40;
    localparam int MS_T = 2;
    localparam logic IDENT = 1'b0; // Arbitrary identity value
    localparam int MS_CYC = MS_T * TICK_CYCLES;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr;
    logic reg_wr, reg_rd, reg_rvalid, burst_ok, crc_append, outside_ref;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [15:0] trim_offset, trim_gain;
    logic [3:0] pulse_fire = 4'h0;
    logic [3:0] pout_n;
    logic first_event = 1'b0;
    logic second_event = 1'b0;
    logic sag_active = 1'b0;
    logic surge_active = 1'b0;
    logic sag_done = 1'b0;
    logic surge_done = 1'b0;
    logic irq_first_n, irq_second_n, ds_event, acc_clear, acc_enable;
    int n_mismatch = 0;
    int comparisons = 0;
    logic [32:0] exp_q[$];
    logic [32:0] note;
    logic [11:0] burst_addr[7] = '{12'h4FF, 12'h500, 12'h63C, 12'h63D, 12'h680, 12'h6BC, 12'h6BD};
    logic burst_exp[7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

    always #10 clk = ~clk;

    host_model host (.CLK(clk), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
        .REG_RD(reg_rd));

    meter_cfg_regs #(.FIXED_US(FIX_US), .MS_TICKS(MS_T), .IDENTITY_BIT(IDENT)) uut (
        .CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .BURST_OK(burst_ok),
        .CRC_APPEND(crc_append), .OUTSIDE_REFERENCE_SELECT(outside_ref),
        .TRIM_OFFSET(trim_offset), .TRIM_GAIN(trim_gain), .PULSE_FIRE(pulse_fire),
        .PULSE_OUTPUT_ONE_N(pout_n[0]), .PULSE_OUTPUT_TWO_N(pout_n[1]),
        .PULSE_OUTPUT_THREE_N(pout_n[2]), .PULSE_OUTPUT_FOUR_N(pout_n[3]),
        .FIRST_EVENT(first_event), .SECOND_EVENT(second_event),
        .INTERRUPT_PIN_FIRST_N(irq_first_n), .INTERRUPT_PIN_SECOND_N(irq_second_n),
        .SAG_ACTIVE(sag_active), .SURGE_ACTIVE(surge_active), .SAG_CYCLE_DONE(sag_done),
        .SURGE_CYCLE_DONE(surge_done), .SAG_SURGE_EVENT(ds_event),
        .PULSE_ACCUMULATOR_CLEAR(acc_clear), .ACCUMULATION_ENABLE(acc_enable));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host.access(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic b = 1'b0);
        exp_q.push_back({b, d});
        host.access(1'b0, a, d);
    endtask : rd

    // Bounded wait; a stuck enable shows as an out-of-range count
    task automatic wait_en(output int n);
        n = 0;
        while (acc_enable !== 1'b1 && n < 40000) begin
            @(negedge clk);
            n++;
        end
    endtask : wait_en

    task automatic fire;
        @(posedge clk) pulse_fire <= 4'hF;
        @(posedge clk) pulse_fire <= 4'h0;
    endtask : fire

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    always @(negedge clk) begin
        if (reg_rvalid === 1'b1 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            check("read data", reg_rdata, note[31:0]);
            check("burst flag", burst_ok, note[32]);
        end else if (reg_rvalid === 1'b1) begin
            check("unexpected read", 32'h1, 32'h0);
        end
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end

    initial begin
        int n;
        int lo[4];
        int ex;
        int tol;
        logic [31:0] r;
        r = $urandom(52);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("crc after reset", crc_append, 1);
        wait_en(n);
        check("first settle", n > 64 * MS_CYC - 100 && n < 64 * MS_CYC + 100, 1);
        rd(OFS_PULSE_WIDTH_CONFIG, 0);
        rd(OFS_PART_IDENTITY, {11'h0, IDENT, 20'h0});
        rd(OFS_TEMPERATURE_TRIM, 0);
        rd(OFS_GLOBAL_CONFIG_ONE, 0);
        $display("done: reset values");
        r = $urandom();
        wr(OFS_PULSE_WIDTH_CONFIG, r);
        rd(OFS_PULSE_WIDTH_CONFIG, r & 32'h007F_FFFF);
        wr(OFS_TEMPERATURE_TRIM, r);
        rd(OFS_TEMPERATURE_TRIM, r);
        check("trim offset", trim_offset, r[31:16]);
        check("trim gain", trim_gain, r[15:0]);
        wr(OFS_PART_IDENTITY, 32'hFFFF_FFFF);
        rd(OFS_PART_IDENTITY, {11'h0, IDENT, 20'h0});
        wr(12'h7FF, r);
        rd(12'h7FF, 0);
        r = $urandom() & 32'hFFFF_FFDF;
        wr(OFS_GLOBAL_CONFIG_ONE, r);
        rd(OFS_GLOBAL_CONFIG_ONE, r & {16'h0, CFG1_WRITE_MASK});
        $display("done: register access");
        wr(OFS_GLOBAL_CONFIG_ONE, 32'h0000_8800);
        repeat (2) @(negedge clk);
        check("outside reference", outside_ref, 1);
        check("crc with burst", crc_append, 0);
        for (int i = 0; i < 7; i++) begin
            rd(burst_addr[i], 0, burst_exp[i]);
        end
        wr(OFS_GLOBAL_CONFIG_ONE, 0);
        rd(BURST_LO_START, 0, 1'b0);
        check("crc restored", crc_append, 1);
        $display("done: burst and crc");
        for (int i = 0; i < 8; i++) begin
            wr(OFS_GLOBAL_CONFIG_ONE, {19'h0, i[2], 12'h0});
            @(posedge clk);
            first_event <= i[0];
            second_event <= i[1];
            @(posedge clk);
            @(negedge clk);
            check("first pin", irq_first_n, !i[0]);
            check("second pin", irq_second_n, !(i[1] | (i[2] & i[0])));
        end
        $display("done: interrupt pins");
        wr(OFS_GLOBAL_CONFIG_ONE, 0);
        @(posedge clk) sag_active <= 1'b1;
        repeat (2) begin
            @(posedge clk) sag_done <= 1'b1;
            @(posedge clk) sag_done <= 1'b0;
            @(negedge clk) check("repeat event", ds_event, 1);
        end
        @(posedge clk) sag_active <= 1'b0;
        wr(OFS_GLOBAL_CONFIG_ONE, 32'h0000_0400);
        @(posedge clk) surge_active <= 1'b1;
        @(posedge clk);
        @(negedge clk) check("entry event", ds_event, 1);
        @(posedge clk) surge_done <= 1'b1;
        @(posedge clk) surge_done <= 1'b0;
        @(negedge clk) check("no repeat", ds_event, 0);
        @(posedge clk) surge_active <= 1'b0;
        @(posedge clk);
        @(negedge clk) check("exit event", ds_event, 1);
        $display("done: dip and swell");
        for (int c = 0; c < 4; c++) begin
            wr(OFS_GLOBAL_CONFIG_ONE, c << 8);
            wr(OFS_GLOBAL_CONFIG_ONE, (c << 8) | 32'h20);
            @(negedge clk);
            check("clear pulse", acc_clear, 1);
            check("enable dropped", acc_enable, 0);
            @(negedge clk);
            check("clear ends", acc_clear, 0);
            wait_en(n);
            ex = (c == 3) ? 0 : (64 * MS_CYC) << c;
            tol = (c == 3) ? 0 : 100;
            check("settle time", n + tol >= ex && n <= ex + tol, 1);
        end
        rd(OFS_GLOBAL_CONFIG_ONE, 32'h0000_0300);
        $display("done: settle and clear");
        // Outputs one and three programmable at 5 us, two and four fixed
        wr(OFS_PULSE_WIDTH_CONFIG, 32'h0028_0005);
        fire();
        repeat (5000) @(posedge clk);
        fire();
        lo = '{0, 0, 0, 0};
        repeat (3000) begin
            @(negedge clk);
            for (int i = 0; i < 4; i++) lo[i] += (pout_n[i] === 1'b0);
        end
        for (int i = 0; i < 4; i++) begin
            ex = i[0] ? FIX_US * TICK_CYCLES : 5 * TICK_CYCLES;
            check("pulse width", lo[i] > ex - 52 && lo[i] < ex + 52, 1);
        end
        $display("done: pulse widths");
        repeat (4) @(negedge clk);
        check("pending reads", exp_q.size(), 0);
        end_sim();
    end
endmodule : tb_metering_config_registers
